// ===== inc/lcdd_if.sv
// Purpose: open-drain two-wire link between host and decoder
// Assumes: pull-ups on both lines
// Notes:   a line is low when any party enables a low drive
`default_nettype none
interface lcdd_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

// ===== inc/lcdd_pkg.sv
// Purpose: types shared by both ends of the lcd command link
// Assumes: constants come from lcdd_regs.svh
// Notes:   state enums and the drive mode type, no codes given
`default_nettype none
package lcdd_pkg;
  typedef enum logic [2:0] {
    LCDD_S_IDLE,
    LCDD_S_ADDR,
    LCDD_S_CMD,
    LCDD_S_DATA,
    LCDD_S_SKIP
  } lcdd_dev_st_t;

  typedef enum logic [2:0] {
    LCDD_H_IDLE,
    LCDD_H_START,
    LCDD_H_BIT,
    LCDD_H_ACK,
    LCDD_H_STOP
  } lcdd_host_st_t;

  typedef logic [1:0] lcdd_mode_t;
endpackage
`default_nettype wire

// ===== inc/lcdd_regs.svh
// Purpose: shared constants of the lcd command decoder link and its host
// Assumes: 25 MHz pclk, open-drain two-wire link
// Notes:   offsets, field positions, reset values and timing counts
`ifndef LCDD_REGS_SVH
`define LCDD_REGS_SVH

// ****************************************************************
// slave address and command patterns
// ****************************************************************
`define LCDD_ADDR_HI        6'h1C
`define LCDD_ADDR_MATCH_W   6
`define LCDD_CONT_BIT       7
`define LCDD_RAM_DEPTH      7'h28
`define LCDD_PAT_MODE       2'h2
`define LCDD_PAT_SUB        4'hC
`define LCDD_PAT_BANK       5'h1E
`define LCDD_PAT_BLINK      4'hE

// ****************************************************************
// reset values of the decoder state
// ****************************************************************
`define LCDD_RST_MODE       2'h0
`define LCDD_RST_EN         1'h0
`define LCDD_RST_BIAS       1'h0

// ****************************************************************
// blink dividers, counted in display clock ticks
// ****************************************************************
`define LCDD_BLINK_DIV1     12'h300
`define LCDD_BLINK_DIV2     12'h600
`define LCDD_BLINK_DIV3     12'hC00

// ****************************************************************
// host register map and timing
// ****************************************************************
`define LCDD_OFF_XFER       12'h000
`define LCDD_OFF_STATUS     12'h004
`define LCDD_OFF_DIV        12'h008
`define LCDD_XFER_START     8
`define LCDD_XFER_STOP      9
`define LCDD_BIT_TIME_NS    10000
`define LCDD_CLK_NS         40
`define LCDD_RST_DIV        16'((`LCDD_BIT_TIME_NS / `LCDD_CLK_NS) / 4)

`endif

// ===== test/lcdd_monitor.sv
// Purpose: wire-level checks of the decoder side of the two-wire link
// Assumes: one host and one decoder on the link, pclk samples both lines
// Notes:   bit count, byte phase and address match are rebuilt from the lines
`default_nettype none
module lcdd_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe,
  input wire logic slave_addr_strap_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // link tracking
  // ****************************************************************
  logic       scl_q, sda_q, first, in_cmd, skip;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       rise, start, stop, done, match;

  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign done  = rise & (cnt == 4'h8);
  assign match = (sh[7:2] == 6'h1C) & (sh[1] == slave_addr_strap_pin) & ~sh[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q  <= 1'h1;
      sda_q  <= 1'h1;
      cnt    <= 4'h0;
      sh     <= 8'h00;
      first  <= 1'h0;
      in_cmd <= 1'h0;
      skip   <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        cnt    <= 4'h0;
        first  <= 1'h1;
        in_cmd <= 1'h0;
        skip   <= 1'h0;
      end else if (stop) begin
        first  <= 1'h0;
        in_cmd <= 1'h0;
        skip   <= 1'h1;
      end else if (rise) begin
        if (cnt != 4'h8) sh <= {sh[6:0], sda};
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (done) begin
          first  <= 1'h0;
          skip   <= first ? ~match : skip;
          in_cmd <= first ? match : in_cmd & sh[7];
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking mcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_ACK_SLOT: assert property (
    d_sda_oe |-> cnt == 4'h9 || (cnt == 4'h8 && (!scl || !scl_q)))
    else $error("decoder drives data line outside the ninth clock");
  AST_ACK_HOLD: assert property (
    d_sda_oe && scl |=> d_sda_oe)
    else $error("acknowledge dropped while clock high");
  AST_EDGE_LOW: assert property (
    $changed(d_sda_oe) |-> !scl)
    else $error("decoder changed data line while clock high");
  AST_ADDR_MATCH: assert property (
    d_sda_oe && first |-> match)
    else $error("address byte acknowledged without a match");
  AST_ADDR_ACK: assert property (
    done && first && match |-> d_sda_oe)
    else $error("matching address byte not acknowledged");
  AST_CMD_ACK: assert property (
    done && in_cmd |-> d_sda_oe)
    else $error("command byte not acknowledged");
  AST_SKIP_QUIET: assert property (
    skip |-> !d_sda_oe)
    else $error("decoder answered while not addressed");
  AST_START_ABORT: assert property (
    start |=> !d_sda_oe [*8])
    else $error("decoder drove data line right after a start");
endmodule // lcdd_monitor
`default_nettype wire

// ===== test/test_lcd_i2c_command_decoder.sv
// Purpose: bench for host and decoder joined on one link
// Assumes: quarter-bit divisor set to 3 before traffic
// Notes:   bytes go out through apb, decoder outputs are compared
`include "lcdd_regs.svh"
`default_nettype none
module test_lcd_i2c_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdd_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, strap, pready, pslverr;
  logic        tick = 1'h0;
  logic [2:0]  hw_sub;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  ram_rd_addr;
  logic [3:0]  ram_rd_data;
  logic        display_on, bias_half, shown_bank, blink_phase;
  logic [1:0]  blink_rate_field, s, dv;
  lcdd_mode_t  drive_mode;
  int          fails = 0, n_compared = 0, i, t0;
  lcdd_if bus ();
  lcdd_host i_lcdd_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(bus.host));
  lcdd_dev i_lcdd_dev (.pclk, .presetn, .slave_addr_strap_pin(strap), .hw_subaddr_pins(hw_sub),
    .disp_clk_tick(tick), .ram_rd_addr, .ram_rd_data, .display_on, .bias_half, .drive_mode,
    .shown_bank, .blink_phase, .blink_rate_field, .bus(bus.dev));
  lcdd_monitor i_lcdd_monitor (.pclk, .presetn, .scl(bus.scl), .sda(bus.sda),
    .d_sda_oe(bus.d_sda_oe), .slave_addr_strap_pin(strap));
  always #20 pclk = ~pclk;
  always @(posedge pclk) tick <= ~tick;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    fails++;
    wrap_up();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) hang();
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // f is {stop, start}; ack expected on the ninth clock
  task automatic xfer(input logic [7:0] b, input logic [1:0] f, input logic ack);
    int k;
    apb(1'h1, `LCDD_OFF_XFER, {22'h0, f, b});
    k = 0;
    do begin
      apb(1'h0, `LCDD_OFF_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'h0 && k < 500);
    if (k >= 500) hang();
    chk(rd[1], ack);
  endtask
  task automatic ram(input logic [5:0] a, input logic [3:0] e);
    ram_rd_addr <= a;
    repeat (3) @(posedge pclk);
    chk(ram_rd_data, e);
  endtask
  task automatic wait_toggle(output int n);
    logic v;
    v = blink_phase;
    n = 0;
    while (blink_phase === v && n < 8000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 8000) hang();
  endtask
  task automatic two_phases(output logic [1:0] r, output logic [1:0] d);
    int n;
    wait_toggle(n);
    repeat (2) @(posedge pclk);
    r[0] = shown_bank;
    d[0] = display_on;
    wait_toggle(n);
    repeat (2) @(posedge pclk);
    r[1] = shown_bank;
    d[1] = display_on;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap = 1'h0;
    hw_sub = 3'h0;
    ram_rd_addr = 6'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    chk(drive_mode, `LCDD_RST_MODE);
    chk(display_on, `LCDD_RST_EN);
    chk(bias_half, `LCDD_RST_BIAS);
    chk(blink_rate_field, 2'h0);
    apb(1'h0, `LCDD_OFF_DIV, 32'h0);
    chk(rd, 32'(`LCDD_RST_DIV));
    apb(1'h0, 12'h0FC, 32'h0);
    chk(rd, 32'h0);
    chk(pslverr, 1'h0);
    apb(1'h1, `LCDD_OFF_DIV, 32'h3);
    $display("reset and host registers done");
    xfer(8'h40, 2'h3, 1'h0);
    xfer(8'h71, 2'h3, 1'h0);
    xfer(8'h72, 2'h3, 1'h0);
    strap <= 1'h1;
    xfer(8'h72, 2'h3, 1'h1);
    xfer(8'h70, 2'h3, 1'h0);
    strap <= 1'h0;
    $display("address filter done");
    xfer(8'h70, 2'h1, 1'h1);
    for (i = 0; i < 4; i++) begin
      xfer(8'hC8 | {3'h0, i[0], 1'h0, i[0], i[1:0]}, 2'h0, 1'h1);
      chk(drive_mode, i[1:0]);
      chk(bias_half, i[0]);
      chk(display_on, 1'h1);
    end
    xfer(8'hC1, 2'h0, 1'h1);
    chk(display_on, 1'h0);
    xfer(8'hC9, 2'h0, 1'h1);
    xfer(8'hF9, 2'h0, 1'h1);
    chk(shown_bank, 1'h1);
    xfer(8'hCB, 2'h0, 1'h1);
    xfer(8'hF8, 2'h0, 1'h1);
    xfer(8'hFC, 2'h0, 1'h1);
    chk(drive_mode, 2'h3);
    xfer(8'hC9, 2'h0, 1'h1);
    chk(shown_bank, 1'h1);
    for (i = 0; i < 4; i++) begin
      xfer(8'hF0 | 8'(i), 2'h0, 1'h1);
      chk(blink_rate_field, i[1:0]);
    end
    $display("command decode done");
    for (i = 1; i < 4; i++) begin
      xfer(8'hF0 | 8'(i), 2'h0, 1'h1);
      wait_toggle(t0);
      wait_toggle(t0);
      chk(t0, 32'(`LCDD_BLINK_DIV1) << (i - 1));
    end
    xfer(8'hF5, 2'h0, 1'h1);
    two_phases(s, dv);
    chk(s[0] ^ s[1], 1'h1);
    chk(dv, 2'h3);
    xfer(8'hC8, 2'h0, 1'h1);
    two_phases(s, dv);
    chk(s, 2'h0);
    chk(dv[0] ^ dv[1], 1'h1);
    xfer(8'hF0, 2'h2, 1'h1);
    $display("blink done");
    xfer(8'h70, 2'h1, 1'h1);
    xfer(8'hE0, 2'h0, 1'h1);
    xfer(8'h05, 2'h0, 1'h1);
    xfer(8'hA5, 2'h0, 1'h1);
    xfer(8'h70, 2'h1, 1'h1);
    xfer(8'hE7, 2'h0, 1'h1);
    xfer(8'h26, 2'h0, 1'h1);
    xfer(8'hFF, 2'h0, 1'h0);
    xfer(8'h3C, 2'h2, 1'h1);
    ram(6'h05, 4'h5);
    ram(6'h06, 4'hA);
    ram(6'h26, 4'h0);
    ram(6'h27, 4'h0);
    ram(6'h00, 4'hC);
    ram(6'h01, 4'h3);
    $display("display data done");
    hw_sub <= 3'h5;
    xfer(8'h70, 2'h1, 1'h1);
    xfer(8'hC9, 2'h0, 1'h1);
    xfer(8'hFA, 2'h0, 1'h1);
    chk(shown_bank, 1'h0);
    xfer(8'hE5, 2'h0, 1'h1);
    xfer(8'h10, 2'h0, 1'h1);
    xfer(8'h81, 2'h2, 1'h1);
    ram(6'h10, 4'h4);
    ram(6'h11, 4'h0);
    ram(6'h17, 4'h4);
    $display("input bank and subaddress done");
    wrap_up();
  end
endmodule // test_lcd_i2c_command_decoder
`default_nettype wire

// ===== verilog/lcdd_dev.sv
// Purpose: write-only two-wire slave and command decoder of an lcd driver
// Assumes: scl and sda are synchronous to pclk; straps stable during access
// Notes:   display ram and blinker sit here; backplane drive does not
// What this block does
// - answer only addresses 0111000 and 0111001
// - reads are never answered; write bit zero
// - address lsb must equal strap pin
// - matching devices acknowledge the address byte
// - every command byte is acknowledged
// - bit 7 clear ends commands, data follows
// - data goes to ram, pointers advance
// - data acked only on subaddress match
// - stop ends, repeated start restarts addressing
// - mode-set bit 2 selects the bias
// - mode-set bits 1:0 select drive mode
// - bit 6 clear loads ram pointer
// - pattern 1100 loads subaddress counter
// - bank command bit 1 picks input bank
// - bank command bit 0 picks output bank
// - bank command ignored in 1:3, 1:4
// - blink command sets mode and rate
// - 1:3 and 1:4 force normal blinking
// - blink divides display clock 768/1536/3072
// - mismatch skips write, pointer still advances
//
// The APB register port and the register offsets were chosen for this implementation.
`default_nettype none
module lcdd_dev
  import lcdd_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             slave_addr_strap_pin,
  input  wire logic [2:0]       hw_subaddr_pins,
  input  wire logic             disp_clk_tick,
  input  wire logic [5:0]       ram_rd_addr,
  output logic      [3:0]       ram_rd_data,
  output logic                  display_on,
  output logic                  bias_half,
  output lcdd_pkg::lcdd_mode_t  drive_mode,
  output logic                  shown_bank,
  output logic                  blink_phase,
  output logic      [1:0]       blink_rate_field,
  lcdd_if.dev                   bus
);
  `include "lcdd_regs.svh"

  typedef struct packed {
    lcdd_dev_st_t       st;
    logic               scl_q;
    logic               sda_q;
    logic [7:0]         shreg;
    logic [3:0]         bitcnt;
    logic               in_ack;
    logic               sda_oe;
    logic               disp_en;
    logic               bias;
    lcdd_mode_t         mode;
    logic               in_bank;
    logic               out_bank;
    logic               blink_alt;
    logic [1:0]         rate;
    logic [5:0]         ptr;
    logic [2:0]         subaddr;
    logic [39:0][3:0]   ram;
    logic [11:0]        bcnt;
    logic               bon;
    logic [3:0]         rd_data;
    logic               disp_out;
    logic               shown;
  } lcdd_dev_s_t;

  lcdd_dev_s_t s;
  lcdd_dev_s_t n;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        dual_ok;
  logic        alt_eff;
  logic        sub_hit;
  logic [7:0]  b;
  logic [6:0]  wa;
  logic [1:0]  wrow;
  logic [6:0]  step;
  logic [6:0]  nxt;
  logic [11:0] half;

  always_comb begin
    n = s;
    b = s.shreg;
    wa = 7'h0;
    wrow = 2'h0;
    step = 7'h2;
    nxt = 7'h0;
    half = 12'h0;
    // ****************************************************************
    // line conditions
    // ****************************************************************
    n.scl_q = bus.scl;
    n.sda_q = bus.sda;
    scl_rise = bus.scl && !s.scl_q;
    scl_fall = !bus.scl && s.scl_q;
    start_c = bus.scl && s.scl_q && s.sda_q && !bus.sda;
    stop_c = bus.scl && s.scl_q && !s.sda_q && bus.sda;
    dual_ok = (s.mode == 2'h1) || (s.mode == 2'h2);
    alt_eff = s.blink_alt && dual_ok;
    sub_hit = (s.subaddr == hw_subaddr_pins);

    // ****************************************************************
    // byte engine and command decoder
    // ****************************************************************
    if (start_c) begin
      n.st = LCDD_S_ADDR;
      n.bitcnt = 4'h0;
      n.in_ack = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = LCDD_S_IDLE;
      n.bitcnt = 4'h0;
      n.in_ack = 1'b0;
      n.sda_oe = 1'b0;
    end else if (s.st != LCDD_S_IDLE && s.st != LCDD_S_SKIP) begin
      if (scl_rise && s.bitcnt < 4'h8) begin
        n.shreg = {s.shreg[6:0], bus.sda};
        n.bitcnt = s.bitcnt + 4'h1;
      end else if (scl_fall && s.in_ack) begin
        n.in_ack = 1'b0;
        n.sda_oe = 1'b0;
        n.bitcnt = 4'h0;
      end else if (scl_fall && s.bitcnt == 4'h8) begin
        n.in_ack = 1'b1;
        case (s.st)
          LCDD_S_ADDR: begin
            if (b[7:2] == `LCDD_ADDR_HI && b[1] == slave_addr_strap_pin
                && !b[0]) begin
              n.sda_oe = 1'b1;
              n.st = LCDD_S_CMD;
            end else begin
              n.st = LCDD_S_SKIP;
            end
          end
          LCDD_S_CMD: begin
            n.sda_oe = 1'b1;
            if (!b[`LCDD_CONT_BIT]) begin
              n.st = LCDD_S_DATA;
            end
            if (!b[6]) begin
              n.ptr = b[5:0];
            end else if (b[6:5] == `LCDD_PAT_MODE) begin
              n.disp_en = b[3];
              n.bias = b[2];
              n.mode = b[1:0];
            end else if (b[6:3] == `LCDD_PAT_SUB) begin
              n.subaddr = b[2:0];
            end else if (b[6:2] == `LCDD_PAT_BANK) begin
              if (dual_ok) begin
                n.in_bank = b[1];
                n.out_bank = b[0];
              end
            end else if (b[6:3] == `LCDD_PAT_BLINK) begin
              n.blink_alt = b[2];
              n.rate = b[1:0];
            end
          end
          LCDD_S_DATA: begin
            n.sda_oe = sub_hit;
            case (s.mode)
              2'h1:    step = 7'h8;
              2'h2:    step = 7'h4;
              2'h3:    step = 7'h3;
              default: step = 7'h2;
            endcase
            for (int i = 0; i < 8; i++) begin
              case (s.mode)
                2'h1: begin
                  wa = {1'b0, s.ptr} + 7'(i);
                  wrow = {s.in_bank, 1'b0};
                end
                2'h2: begin
                  wa = {1'b0, s.ptr} + 7'(i / 2);
                  wrow = {s.in_bank, 1'(i % 2)};
                end
                2'h3: begin
                  wa = {1'b0, s.ptr} + 7'(i / 3);
                  wrow = 2'(i % 3);
                end
                default: begin
                  wa = {1'b0, s.ptr} + 7'(i / 4);
                  wrow = 2'(i % 4);
                end
              endcase
              if (sub_hit && wa < `LCDD_RAM_DEPTH) begin
                n.ram[6'(wa)][wrow] = b[7 - i];
              end
            end
            nxt = {1'b0, s.ptr} + step;
            if (nxt >= `LCDD_RAM_DEPTH) begin
              n.ptr = 6'(nxt - `LCDD_RAM_DEPTH);
              n.subaddr = s.subaddr + 3'h1;
            end else begin
              n.ptr = nxt[5:0];
            end
          end
          default: n.st = LCDD_S_SKIP;
        endcase
      end
    end

    // ****************************************************************
    // blinker and display outputs
    // ****************************************************************
    case (s.rate)
      2'h1:    half = `LCDD_BLINK_DIV1 >> 1;
      2'h2:    half = `LCDD_BLINK_DIV2 >> 1;
      2'h3:    half = `LCDD_BLINK_DIV3 >> 1;
      default: half = 12'h0;
    endcase
    if (s.rate == 2'h0) begin
      n.bcnt = 12'h0;
      n.bon = 1'b0;
    end else if (disp_clk_tick) begin
      if (s.bcnt >= half - 12'h1) begin
        n.bcnt = 12'h0;
        n.bon = !s.bon;
      end else begin
        n.bcnt = s.bcnt + 12'h1;
      end
    end
    n.disp_out = s.disp_en && !(s.bon && !alt_eff);
    n.shown = dual_ok && (s.out_bank ^ (alt_eff && s.bon));
    n.rd_data = (ram_rd_addr < 6'(`LCDD_RAM_DEPTH)) ? s.ram[ram_rd_addr] : 4'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= LCDD_S_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.mode <= `LCDD_RST_MODE;
      s.disp_en <= `LCDD_RST_EN;
      s.bias <= `LCDD_RST_BIAS;
    end else begin
      s <= n;
    end
  end

  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = s.sda_oe;
  assign ram_rd_data = s.rd_data;
  assign display_on = s.disp_out;
  assign bias_half = s.bias;
  assign drive_mode = s.mode;
  assign shown_bank = s.shown;
  assign blink_phase = s.bon;
  assign blink_rate_field = s.rate;
endmodule // lcdd_dev
`default_nettype wire

// ===== verilog/lcdd_host.sv
// Purpose: apb-controlled byte master for the lcd command link
// Assumes: one byte per xfer write, status polled by software
// Notes:   writes to xfer while busy are dropped
`default_nettype none
module lcdd_host
  import lcdd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  lcdd_if.host             bus
);
  `include "lcdd_regs.svh"

  typedef struct packed {
    lcdd_host_st_t st;
    logic [1:0]    q;
    logic [2:0]    bitn;
    logic [15:0]   divcnt;
    logic [15:0]   div;
    logic [9:0]    xfer;
    logic          acked;
    logic          scl_oe;
    logic          sda_oe;
    logic [31:0]   prdata;
    logic          pready;
  } lcdd_host_s_t;

  lcdd_host_s_t s;
  lcdd_host_s_t n;
  logic         tick;
  logic         wr;
  logic         last_q;

  // ****************************************************************
  // register slave and bit sequencer
  // ****************************************************************
  always_comb begin
    n = s;
    tick = (s.divcnt >= s.div);
    last_q = tick && (s.q == 2'h3);
    // a write lands at the edge that completes the access, with pready high
    wr = psel && penable && s.pready && pwrite;
    n.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready && !pwrite) begin
      case (paddr)
        `LCDD_OFF_XFER:   n.prdata = {22'h0, s.xfer};
        `LCDD_OFF_STATUS: n.prdata = {30'h0, s.acked, s.st != LCDD_H_IDLE};
        `LCDD_OFF_DIV:    n.prdata = {16'h0, s.div};
        default:          n.prdata = 32'h0;
      endcase
    end
    if (wr && paddr == `LCDD_OFF_DIV) begin
      n.div = pwdata[15:0];
    end
    n.divcnt = (s.st == LCDD_H_IDLE || tick) ? 16'h0 : s.divcnt + 16'h1;
    if (tick) begin
      n.q = s.q + 2'h1;
    end
    case (s.st)
      LCDD_H_IDLE: begin
        n.q = 2'h0;
        if (wr && paddr == `LCDD_OFF_XFER) begin
          n.xfer = pwdata[9:0];
          n.bitn = 3'h7;
          n.st = pwdata[`LCDD_XFER_START] ? LCDD_H_START : LCDD_H_BIT;
        end
      end
      LCDD_H_START: begin
        // works from idle and for a repeated start after an ack
        if (tick) begin
          case (s.q)
            2'h0:    n.sda_oe = 1'b0;
            2'h1:    n.scl_oe = 1'b0;
            2'h2:    n.sda_oe = 1'b1;
            default: n.scl_oe = 1'b1;
          endcase
        end
        if (last_q) begin
          n.st = LCDD_H_BIT;
        end
      end
      LCDD_H_BIT: begin
        if (tick) begin
          case (s.q)
            2'h0:    n.sda_oe = !s.xfer[s.bitn];
            2'h1:    n.scl_oe = 1'b0;
            2'h2:    n.scl_oe = 1'b0;
            default: n.scl_oe = 1'b1;
          endcase
        end
        if (last_q) begin
          n.bitn = s.bitn - 3'h1;
          n.st = (s.bitn == 3'h0) ? LCDD_H_ACK : LCDD_H_BIT;
        end
      end
      LCDD_H_ACK: begin
        if (tick) begin
          case (s.q)
            2'h0:    n.sda_oe = 1'b0;
            2'h1:    n.scl_oe = 1'b0;
            2'h2:    n.acked = !bus.sda;
            default: n.scl_oe = 1'b1;
          endcase
        end
        if (last_q) begin
          n.st = s.xfer[`LCDD_XFER_STOP] ? LCDD_H_STOP : LCDD_H_IDLE;
        end
      end
      LCDD_H_STOP: begin
        if (tick) begin
          case (s.q)
            2'h0:    n.sda_oe = 1'b1;
            2'h1:    n.scl_oe = 1'b0;
            2'h2:    n.sda_oe = 1'b0;
            default: n.scl_oe = 1'b0;
          endcase
        end
        if (last_q) begin
          n.st = LCDD_H_IDLE;
        end
      end
      default: n.st = LCDD_H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= LCDD_H_IDLE;
      s.div <= `LCDD_RST_DIV;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = 1'b0;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = s.scl_oe;
  assign bus.m_sda_oe = s.sda_oe;
endmodule // lcdd_host
`default_nettype wire
